/* src/pco_device.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - overrides reached only via 0x40-0x42
// - host selects page 0x10 first
// - bit7 of 0x47 forces divider reset
// - bit5 forces lock indication low
// - host writes reserved bits as zero
// - 0x49 bit4 enables forced state
// - bits3:0 code: 0 reset, 6 wait
// - host writes 0x16 to 0x49
// - host writes 0x20 to 0x47 four times
// - host writes 0x00 to release lock
// - host writes 0x00 to 0x49 last
// - power-down pin after supplies settle
// - no inputs driven before supplies steady
// - controller logic drives power-down pin
module pco_device (
    input  wire logic CLK,
    input  wire logic RSTN,
    pco_if.device     BUS,
    output logic      DIVIDER_RESET_FORCE,
    output logic      PLL_LOCK,
    output logic      PLL_IN_RESET,
    output logic [3:0] PLL_STATE
);
    typedef enum logic [1:0] {PC_RESET, PC_WAIT, PC_LOCKED} pco_pc_t;

    // code shown once locked; zero byte for cleared registers
    localparam logic [3:0] ST_CODE_LOCKED = 4'hF;
    localparam logic [7:0] BYTE_ZERO      = 8'h00;

    logic [1:0] pd_sync_q;
    logic [7:0] page_q, page_d;
    logic [7:0] ofs_q, ofs_d;
    logic [7:0] lock_ovr_q, lock_ovr_d;
    logic [7:0] st_force_q, st_force_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] wait_q, wait_d;
    pco_pc_t    pc_q, pc_d;
    logic       lock_q, lock_d;
    logic       in_rst_q, in_rst_d;
    logic [3:0] code_q, code_d;
    logic       rst_n;
    logic       hit_lock;
    logic       hit_state;

    // paged access hits an override register only inside the video input page
    function automatic logic paged_hit(input logic [7:0] page, input logic [7:0] ofs, input logic [7:0] target);
        paged_hit = (page == pco_pkg::VIDEO_INPUT_PAGE) && (ofs == target);
    endfunction

    // controller state to the code shown on PLL_STATE
    function automatic logic [3:0] state_code(input pco_pc_t s);
        case (s)
            PC_RESET: state_code = pco_pkg::ST_CODE_RESET;
            PC_WAIT:  state_code = pco_pkg::ST_CODE_LOOP_WAIT;
            default:  state_code = ST_CODE_LOCKED;
        endcase
    endfunction

    // power-down pin acts as reset alongside RSTN
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pd_sync_q <= 2'h0;
        end else begin
            pd_sync_q <= {pd_sync_q[0], BUS.power_down_n_pin};
        end
    end
    assign rst_n     = pd_sync_q[1];
    assign hit_lock  = paged_hit(page_q, ofs_q, pco_pkg::OFS_LOCK_OVR);
    assign hit_state = paged_hit(page_q, ofs_q, pco_pkg::OFS_STATE_FORCE);

    // register file: power-down clear, paged writes, one-cycle read answer
    always_comb begin
        page_d     = page_q;
        ofs_d      = ofs_q;
        lock_ovr_d = lock_ovr_q;
        st_force_d = st_force_q;
        rdata_d    = BYTE_ZERO;
        if (!rst_n) begin
            page_d     = BYTE_ZERO;
            ofs_d      = BYTE_ZERO;
            lock_ovr_d = pco_pkg::LOCK_OVR_RESET;
            st_force_d = pco_pkg::STATE_FORCE_RST;
        end else begin
            if (BUS.wr) begin
                case (BUS.addr)
                    pco_pkg::REG_PAGE_SEL:    page_d = BUS.wdata;
                    pco_pkg::REG_PAGE_OFFSET: ofs_d  = BUS.wdata;
                    pco_pkg::REG_PAGE_DATA: begin
                        if (hit_lock) begin
                            lock_ovr_d = BUS.wdata & pco_pkg::LOCK_OVR_WMASK;
                        end else if (hit_state) begin
                            st_force_d = BUS.wdata & pco_pkg::STATE_FORCE_WMASK;
                        end
                    end
                    default: ;
                endcase
            end
            if (BUS.rd) begin
                case (BUS.addr)
                    pco_pkg::REG_PAGE_SEL:    rdata_d = page_q;
                    pco_pkg::REG_PAGE_OFFSET: rdata_d = ofs_q;
                    pco_pkg::REG_PAGE_DATA: begin
                        if (hit_lock) begin
                            rdata_d = lock_ovr_q;
                        end else if (hit_state) begin
                            rdata_d = st_force_q;
                        end
                    end
                    default: rdata_d = BYTE_ZERO;
                endcase
            end
        end
    end

    // own PLL controller sequencing
    always_comb begin
        pc_d   = pc_q;
        wait_d = wait_q;
        // synced pin low holds the controller in reset
        if (!rst_n) begin
            pc_d   = PC_RESET;
            wait_d = BYTE_ZERO;
        end else if (st_force_q[pco_pkg::BIT_STATE_EN]) begin
            if (st_force_q[3:0] == pco_pkg::ST_CODE_LOOP_WAIT) begin
                pc_d   = PC_WAIT;
                wait_d = BYTE_ZERO;
            end else begin
                pc_d   = PC_RESET;
                wait_d = BYTE_ZERO;
            end
        end else begin
            case (pc_q)
                PC_RESET: begin
                    if (!lock_ovr_q[pco_pkg::BIT_DIV_RST]) begin
                        pc_d   = PC_WAIT;
                        wait_d = BYTE_ZERO;
                    end
                end
                PC_WAIT: begin
                    if (wait_q == pco_pkg::PLL_WAIT_CYCLES) begin
                        pc_d = PC_LOCKED;
                    end else begin
                        wait_d = wait_q + 8'h01;
                    end
                end
                PC_LOCKED: ;
                default: pc_d = PC_RESET;
            endcase
        end
    end

    // status taken from next values, so flops add no lag
    always_comb begin
        lock_d   = (pc_d == PC_LOCKED) && !lock_ovr_d[pco_pkg::BIT_LOCK_FORCE];
        in_rst_d = (pc_d == PC_RESET);
        code_d   = state_code(pc_d);
    end

    // register file flops
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            page_q     <= BYTE_ZERO;
            ofs_q      <= BYTE_ZERO;
            lock_ovr_q <= pco_pkg::LOCK_OVR_RESET;
            st_force_q <= pco_pkg::STATE_FORCE_RST;
            rdata_q    <= BYTE_ZERO;
        end else begin
            page_q     <= page_d;
            ofs_q      <= ofs_d;
            lock_ovr_q <= lock_ovr_d;
            st_force_q <= st_force_d;
            rdata_q    <= rdata_d;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pc_q   <= PC_RESET;
            wait_q <= BYTE_ZERO;
        end else begin
            pc_q   <= pc_d;
            wait_q <= wait_d;
        end
    end

    // outputs held in flops so they change only on the clock
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            lock_q   <= 1'b0;
            in_rst_q <= 1'b1;
            code_q   <= pco_pkg::ST_CODE_RESET;
        end else begin
            lock_q   <= lock_d;
            in_rst_q <= in_rst_d;
            code_q   <= code_d;
        end
    end

    assign BUS.rdata           = rdata_q;
    assign DIVIDER_RESET_FORCE = lock_ovr_q[pco_pkg::BIT_DIV_RST];
    assign PLL_LOCK            = lock_q;
    assign PLL_IN_RESET        = in_rst_q;
    assign PLL_STATE           = code_q;
endmodule

/* src/pco_pkg.sv */
package pco_pkg;
    localparam logic [7:0] REG_PAGE_SEL     = 8'h40;
    localparam logic [7:0] REG_PAGE_OFFSET  = 8'h41;
    localparam logic [7:0] REG_PAGE_DATA    = 8'h42;
    localparam logic [7:0] VIDEO_INPUT_PAGE = 8'h10;
    localparam logic [7:0] OFS_LOCK_OVR     = 8'h47;
    localparam logic [7:0] OFS_STATE_FORCE  = 8'h49;
    localparam logic [7:0] LOCK_OVR_RESET   = 8'h00;
    localparam logic [7:0] STATE_FORCE_RST  = 8'h00;
    localparam logic [7:0] LOCK_OVR_WMASK   = 8'hA0;
    localparam logic [7:0] STATE_FORCE_WMASK = 8'h1F;
    localparam int         BIT_DIV_RST      = 7;
    localparam int         BIT_LOCK_FORCE   = 5;
    localparam int         BIT_STATE_EN     = 4;
    localparam logic [3:0] ST_CODE_RESET    = 4'h0;
    localparam logic [3:0] ST_CODE_LOOP_WAIT = 4'h6;
    localparam logic [7:0] SEQ_STATE_HOLD   = 8'h16;
    localparam logic [7:0] SEQ_LOCK_LOW     = 8'h20;
    localparam logic [7:0] SEQ_RELEASE      = 8'h00;
    localparam int         SEQ_LOCK_REPEAT  = 4;
    // host command/status port
    localparam logic [1:0] CMD_CTRL   = 2'h0;
    localparam logic [1:0] CMD_STATUS = 2'h1;
    localparam logic [1:0] CMD_SETTLE = 2'h2;
    localparam logic [31:0] SETTLE_CYCLES_DEF = 32'h0000_0100;
    localparam logic [7:0] PLL_WAIT_CYCLES = 8'h10;
endpackage

/* src/pco_if.sv */
`timescale 1ns/1ns
interface pco_if;
    logic       power_down_n_pin;
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport device (input power_down_n_pin, input wr, input rd, input addr, input wdata, output rdata);
    modport host   (output power_down_n_pin, output wr, output rd, output addr, output wdata, input rdata);
endinterface

/* src/pco_host.sv */
`timescale 1ns/1ns
module pco_host #(
    parameter logic [31:0] SETTLE_CYCLES = pco_pkg::SETTLE_CYCLES_DEF
) (
    input  wire logic       CLK,
    input  wire logic       RSTN,
    pco_if.host             BUS,
    input  wire logic [1:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic [7:0]      RDATA
);
    typedef enum logic [1:0] {HS_OFF, HS_SETTLE, HS_INIT, HS_DONE} pco_hs_t;

    localparam int NSTEP = 11;
    localparam logic [3:0] LAST_STEP = 4'(NSTEP - 1);

    pco_hs_t     st_q, st_d;
    logic [31:0] cnt_q, cnt_d;
    logic [3:0]  step_q, step_d;
    logic        start_q, start_d;
    logic        pd_q, pd_d;
    logic        wr_q, wr_d;
    logic [7:0]  addr_q, addr_d;
    logic [7:0]  wdata_q, wdata_d;
    logic [7:0]  rdata_q, rdata_d;
    logic [31:0] settle_q, settle_d;

    // fixed start-up script: bus offset and value per step
    function automatic logic [15:0] step_word(input logic [3:0] s);
        case (s)
            4'h0: step_word = {pco_pkg::REG_PAGE_SEL,    pco_pkg::VIDEO_INPUT_PAGE};
            4'h1: step_word = {pco_pkg::REG_PAGE_OFFSET, pco_pkg::OFS_STATE_FORCE};
            4'h2: step_word = {pco_pkg::REG_PAGE_DATA,   pco_pkg::SEQ_STATE_HOLD};
            4'h3: step_word = {pco_pkg::REG_PAGE_OFFSET, pco_pkg::OFS_LOCK_OVR};
            4'h4, 4'h5, 4'h6,
            4'h7: step_word = {pco_pkg::REG_PAGE_DATA,   pco_pkg::SEQ_LOCK_LOW};
            4'h8: step_word = {pco_pkg::REG_PAGE_DATA,   pco_pkg::SEQ_RELEASE};
            4'h9: step_word = {pco_pkg::REG_PAGE_OFFSET, pco_pkg::OFS_STATE_FORCE};
            default: step_word = {pco_pkg::REG_PAGE_DATA, pco_pkg::SEQ_RELEASE};
        endcase
    endfunction

    always_comb begin
        st_d     = st_q;
        cnt_d    = cnt_q;
        step_d   = step_q;
        start_d  = 1'b0;
        pd_d     = pd_q;
        wr_d     = 1'b0;
        addr_d   = addr_q;
        wdata_d  = wdata_q;
        rdata_d  = 8'h00;
        settle_d = settle_q;
        if (WR && ADDR == pco_pkg::CMD_CTRL) begin
            start_d = WDATA[0];
        end
        if (WR && ADDR == pco_pkg::CMD_SETTLE) begin
            settle_d = {24'h000000, WDATA};
        end
        if (RD) begin
            case (ADDR)
                pco_pkg::CMD_STATUS: rdata_d = {4'h0, 2'(st_q), 1'b0, pd_q};
                pco_pkg::CMD_SETTLE: rdata_d = settle_q[7:0];
                default:             rdata_d = BUS.rdata;
            endcase
        end
        case (st_q)
            HS_OFF: begin
                pd_d = 1'b0;
                if (start_q) begin
                    st_d  = HS_SETTLE;
                    cnt_d = 32'h0;
                end
            end
            HS_SETTLE: begin
                if (cnt_q >= settle_q) begin
                    pd_d   = 1'b1;
                    st_d   = HS_INIT;
                    step_d = 4'h0;
                    cnt_d  = 32'h0;
                end else begin
                    cnt_d = cnt_q + 32'h1;
                end
            end
            HS_INIT: begin
                if (cnt_q < {24'h000000, pco_pkg::PLL_WAIT_CYCLES}) begin
                    cnt_d = cnt_q + 32'h1;
                end else if (!wr_q) begin
                    wr_d              = 1'b1;
                    {addr_d, wdata_d} = step_word(step_q);
                    if (step_q == LAST_STEP) begin
                        st_d = HS_DONE;
                    end else begin
                        step_d = step_q + 4'h1;
                    end
                end
            end
            HS_DONE: ;
            default: st_d = HS_OFF;
        endcase
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_q     <= HS_OFF;
            cnt_q    <= 32'h0;
            step_q   <= 4'h0;
            start_q  <= 1'b0;
            pd_q     <= 1'b0;
            wr_q     <= 1'b0;
            addr_q   <= 8'h00;
            wdata_q  <= 8'h00;
            rdata_q  <= 8'h00;
            settle_q <= SETTLE_CYCLES;
        end else begin
            st_q     <= st_d;
            cnt_q    <= cnt_d;
            step_q   <= step_d;
            start_q  <= start_d;
            pd_q     <= pd_d;
            wr_q     <= wr_d;
            addr_q   <= addr_d;
            wdata_q  <= wdata_d;
            rdata_q  <= rdata_d;
            settle_q <= settle_d;
        end
    end

    assign BUS.power_down_n_pin = pd_q;
    assign BUS.wr               = wr_q;
    assign BUS.rd               = 1'b0;
    assign BUS.addr             = addr_q;
    assign BUS.wdata            = wdata_q;
    assign RDATA                = rdata_q;
endmodule

/* test/pco_properties.sv */
`timescale 1ns/1ns
module pco_properties (
    input wire logic       CLK,
    input wire logic       RSTN,
    input wire logic       power_down_n_pin,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       DIVIDER_RESET_FORCE,
    input wire logic       PLL_LOCK,
    input wire logic       PLL_IN_RESET,
    input wire logic [3:0] PLL_STATE
);
    logic [7:0] pg_q, of_q, lk_q, st_q;
    logic       wd_lk, wd_st;
    // shadow of the paged registers as the host writes them
    assign wd_lk = addr == pco_pkg::REG_PAGE_DATA && pg_q == pco_pkg::VIDEO_INPUT_PAGE
                   && of_q == pco_pkg::OFS_LOCK_OVR;
    assign wd_st = addr == pco_pkg::REG_PAGE_DATA && pg_q == pco_pkg::VIDEO_INPUT_PAGE
                   && of_q == pco_pkg::OFS_STATE_FORCE;
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            {pg_q, of_q, lk_q, st_q} <= 32'h0;
        end else if (!power_down_n_pin) begin
            {pg_q, of_q, lk_q, st_q} <= 32'h0;
        end else if (wr) begin
            pg_q <= addr == pco_pkg::REG_PAGE_SEL ? wdata : pg_q;
            of_q <= addr == pco_pkg::REG_PAGE_OFFSET ? wdata : of_q;
            lk_q <= wd_lk ? wdata & pco_pkg::LOCK_OVR_WMASK : lk_q;
            st_q <= wd_st ? wdata & pco_pkg::STATE_FORCE_WMASK : st_q;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    property p_rdata_stands; !$past(rd) |-> rdata == 8'h00; endproperty
    a_rdata_stands: assert property (p_rdata_stands) else $error("read data outside its cycle");
    property p_strobe_excl; !(wr && rd); endproperty
    a_strobe_excl: assert property (p_strobe_excl) else $error("read and write strobes together");
    property p_quiet_off; !power_down_n_pin |-> !wr && !rd; endproperty
    a_quiet_off: assert property (p_quiet_off) else $error("bus driven while powered down");
    property p_div_force; wr && wd_lk |=> DIVIDER_RESET_FORCE == lk_q[pco_pkg::BIT_DIV_RST]; endproperty
    a_div_force: assert property (p_div_force) else $error("divider force not following bit 7");
    property p_lock_low; lk_q[5] && $past(lk_q[5]) |-> !PLL_LOCK; endproperty
    a_lock_low: assert property (p_lock_low) else $error("lock high while forced low");
    property p_lock_cause; PLL_LOCK |-> PLL_STATE == 4'hF && !PLL_IN_RESET && !lk_q[5]; endproperty
    a_lock_cause: assert property (p_lock_cause) else $error("lock without locked state");
    property p_force_wait; (st_q[4] && st_q[3:0] == 4'h6) [*4] |-> PLL_STATE == pco_pkg::ST_CODE_LOOP_WAIT; endproperty
    a_force_wait: assert property (p_force_wait) else $error("forced state not taken");
    property p_in_reset; PLL_IN_RESET |-> PLL_STATE == pco_pkg::ST_CODE_RESET; endproperty
    a_in_reset: assert property (p_in_reset) else $error("reset flag with other state");
    property p_release; $fell(st_q[4]) |-> ##[1:300] PLL_STATE == 4'hF; endproperty
    a_release: assert property (p_release) else $error("controller not running after release");
    property p_wr_gap; wr |=> !wr; endproperty
    a_wr_gap: assert property (p_wr_gap) else $error("writes not spaced");
    c_lock_wr: cover property (wr && wd_lk);
    c_wait_state: cover property (PLL_STATE == 4'h6);
    c_locked: cover property ($rose(PLL_LOCK));
endmodule

/* test/pll_ctrl_override_init_tb.sv */
`timescale 1ns/1ns
module pll_ctrl_override_init_tb;
    localparam logic [15:0] SCRIPT [11] = '{16'h4010, 16'h4149, 16'h4216, 16'h4147, 16'h4220, 16'h4220,
                                           16'h4220, 16'h4220, 16'h4200, 16'h4149, 16'h4200};
    logic        clk, rstn, c_wr, c_rd, div_f, lock, in_rst;
    logic [1:0]  c_addr;
    logic [7:0]  c_wdata, c_rdata, s;
    logic [3:0]  st;
    logic [15:0] seen [32];
    int          mismatches, tests_run, n_wr;
    pco_if bus ();
    pco_device u_pco_device (.CLK(clk), .RSTN(rstn), .BUS(bus), .DIVIDER_RESET_FORCE(div_f), .PLL_LOCK(lock),
                             .PLL_IN_RESET(in_rst), .PLL_STATE(st));
    pco_host u_pco_host (.CLK(clk), .RSTN(rstn), .BUS(bus), .ADDR(c_addr), .WDATA(c_wdata), .WR(c_wr), .RD(c_rd),
                         .RDATA(c_rdata));
    pco_properties u_pco_properties (.CLK(clk), .RSTN(rstn), .power_down_n_pin(bus.power_down_n_pin), .wr(bus.wr),
        .rd(bus.rd), .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .DIVIDER_RESET_FORCE(div_f),
        .PLL_LOCK(lock), .PLL_IN_RESET(in_rst), .PLL_STATE(st));
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    // log the first 32 writes the host puts on the link
    always @(posedge clk) begin
        if (bus.wr === 1'h1 && n_wr < 32) begin
            seen[n_wr] <= {bus.addr, bus.wdata};
            n_wr <= n_wr + 1;
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cmd_write(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        c_addr <= a;
        c_wdata <= d;
        c_wr <= 1'h1;
        @(posedge clk);
        c_wr <= 1'h0;
    endtask
    task automatic cmd_read(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        c_addr <= a;
        c_rd <= 1'h1;
        @(posedge clk);
        c_rd <= 1'h0;
        #1 d = c_rdata;
    endtask
    task automatic wait_state(input logic [1:0] want);
        for (int i = 0; i < 500; i++) begin
            cmd_read(pco_pkg::CMD_STATUS, s);
            if (s[3:2] === want) return;
        end
        mismatches++;
        $display("[FAIL] host state expected %h seen %h", want, s[3:2]);
        wrap_up();
    endtask
    task automatic run_init(input string tname);
        n_wr = 0;
        cmd_write(pco_pkg::CMD_SETTLE, 8'h08);
        cmd_write(pco_pkg::CMD_CTRL, 8'h01);
        cmd_read(pco_pkg::CMD_STATUS, s);
        chk("pin low while settling", 16'h0000, {15'h0, s[0]});
        chk("link quiet while settling", 16'h0000, n_wr[15:0]);
        wait_state(2'h3);
        cmd_read(pco_pkg::CMD_STATUS, s);
        chk("pin released", 16'h0001, {15'h0, s[0]});
        chk("write count", 16'h000B, n_wr[15:0]);
        for (int k = 0; k < 11; k++) begin
            chk("init write", SCRIPT[k], seen[k]);
        end
        chk("divider force", 16'h0000, {15'h0, div_f});
        for (int k = 0; k < 400 && lock !== 1'h1; k++) begin
            @(posedge clk);
            #1;
        end
        chk("lock after release", 16'h0001, {15'h0, lock});
        chk("running state", 16'h000F, {12'h0, st});
        $display("test %s done", tname);
    endtask
    initial begin
        {rstn, c_wr, c_rd} = 3'h0;
        c_addr = 2'h0;
        c_wdata = 8'h00;
        {mismatches, tests_run, n_wr} = '0;
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        #1 chk("reset state", 16'h0010, {11'h0, in_rst, st});
        run_init("power-up");
        cmd_write(pco_pkg::CMD_CTRL, 8'h01);
        cmd_read(pco_pkg::CMD_STATUS, s);
        chk("restart refused", 16'h000D, {8'h00, s});
        chk("no second script", 16'h000B, n_wr[15:0]);
        cmd_read(2'h3, s);
        chk("unmapped read", 16'h0000, {8'h00, s});
        $display("test refusal done");
        // only reset leaves the done state, so restart from a fresh reset
        @(posedge clk);
        rstn <= 1'h0;
        @(posedge clk);
        rstn <= 1'h1;
        n_wr = 0;
        cmd_write(pco_pkg::CMD_SETTLE, 8'h08);
        cmd_write(pco_pkg::CMD_CTRL, 8'h01);
        wait_state(2'h2);
        @(posedge clk);
        rstn <= 1'h0;
        @(posedge clk);
        #1 chk("mid-run reset", 16'h0010, {div_f, lock, 9'h0, in_rst, st});
        @(posedge clk);
        rstn <= 1'h1;
        run_init("rerun after reset");
        wrap_up();
    end
    initial begin
        #200000;
        mismatches++;
        $display("[FAIL] run expected done seen hang");
        wrap_up();
    end
endmodule
